// ---- design/serial_master_unit.sv ----
// serial_master_unit: 8-bit full-duplex spi master with tx holding buffer and rx buffer
// assumes slave selects are driven elsewhere by software; miso is an async pin
// Function
// - exchange exactly eight bits per transfer
// - modes 0/1 sample leading, change trailing
// - modes 2/3 sample trailing, change leading
// - selectable lsb or msb first order
// - sclk is half the selected input clock
// - mosi and miso share one sclk
// - enable bit starts, clearing stops block
// - tx write clears buffer empty flag
// - idle shifter loads new byte next clock
// - preloaded byte follows without idle gap
// - one sclk per bit, shift miso in
// - eighth bit: rx buffer, full, done set
// - done with interrupts enabled and shift-finished source selected raises irq
// - unread rx byte overwritten sets overrun
// - irq on holding empty or shift finished
// - input clock is system_clock/1 to /128
`timescale 1ns/1ps
`default_nettype none
module serial_master_unit
	import spi_master_pkg::*;
#(
	parameter int DATA_W = BYTE_BITS
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic enable,
	input wire logic [1:0] mode,
	input wire logic lsb_first,
	input wire logic [2:0] clk_sel,
	input wire logic int_enable,
	input wire logic irq_on_shift_finished,
	input wire logic [DATA_W-1:0] tx_data,
	input wire logic tx_write,
	input wire logic rx_read,
	input wire logic miso,
	output logic sclk,
	output logic mosi,
	output logic [DATA_W-1:0] rx_data,
	output logic tx_empty,
	output logic rx_full,
	output logic done,
	output logic overrun,
	output logic busy,
	output logic irq
);
	// mode bit 0 is polarity, bit 1 is phase (trailing-edge sampling)
	logic cpol;
	logic cpha;
	logic tick;
	logic miso_s1_q;
	logic miso_s2_q;
	logic [DATA_W-1:0] hold_q;
	logic [DATA_W-1:0] shift_q;
	logic [3:0] bitcnt_q;
	shift_state_type state_q;
	logic last_bit;
	logic load_now;
	logic finish;
	logic moved_q;
	logic sample_bit;

	assign cpol = mode[0];
	assign cpha = mode[1];

	// bit-rate tick; two ticks make one sclk period
	rate_divider u_div (
		.mclk(mclk),
		.rst(rst),
		.run(enable),
		.sel(clk_sel),
		.tick(tick)
	);

	// miso is asynchronous to mclk
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			miso_s1_q <= 1'b0;
			miso_s2_q <= 1'b0;
		end else begin
			miso_s1_q <= miso;
			miso_s2_q <= miso_s1_q;
		end
	end

	assign last_bit = (bitcnt_q == 4'(DATA_W - 1));
	assign finish = tick && (state_q == ST_TRAIL) && last_bit;
	// idle shifter takes a waiting byte at once; busy shifter takes it as the byte finishes
	assign load_now = enable && !tx_empty && ((state_q == ST_IDLE) || finish);

	function automatic logic out_bit(input logic [DATA_W-1:0] v, input logic lsb);
		out_bit = lsb ? v[0] : v[DATA_W-1];
	endfunction

	// holding buffer and its empty flag; write beats the move on the same cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hold_q <= BYTE_RESET;
			tx_empty <= 1'b1;
		end else if (tx_write) begin
			hold_q <= tx_data;
			tx_empty <= 1'b0;
		end else if (load_now) begin
			tx_empty <= 1'b1;
		end
	end

	// sampling happens on the leading half for cpha=0, trailing half for cpha=1
	assign sample_bit = tick && ((state_q == ST_LEAD) != cpha);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			bitcnt_q <= BITCNT_RESET;
			shift_q <= BYTE_RESET;
			sclk <= 1'b0;
			mosi <= 1'b0;
		end else if (!enable) begin
			state_q <= ST_IDLE;
			bitcnt_q <= BITCNT_RESET;
			sclk <= cpol;
		end else if (load_now) begin
			shift_q <= hold_q;
			bitcnt_q <= BITCNT_RESET;
			state_q <= ST_LEAD;
			sclk <= cpol;
			// cpha=0 presents the first bit before the leading edge; cpha=1 waits for it,
			// so a back-to-back load never moves mosi on the last sampling edge
			if (!cpha) begin
				mosi <= out_bit(hold_q, lsb_first);
			end
		end else if (state_q == ST_IDLE) begin
			sclk <= cpol;
		end else if (tick) begin
			unique case (state_q)
				ST_LEAD: begin
					sclk <= !cpol;
					state_q <= ST_TRAIL;
					if (cpha) begin
						mosi <= out_bit(shift_q, lsb_first);
					end
				end
				ST_TRAIL: begin
					sclk <= cpol;
					if (last_bit) begin
						state_q <= ST_IDLE;
					end else begin
						state_q <= ST_LEAD;
						bitcnt_q <= bitcnt_q + 4'h1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
			if (sample_bit) begin
				// shift in from the far end so the byte lands in chosen order
				if (lsb_first) begin
					shift_q <= {miso_s2_q, shift_q[DATA_W-1:1]};
					if (!cpha && state_q == ST_TRAIL) mosi <= shift_q[1];
				end else begin
					shift_q <= {shift_q[DATA_W-2:0], miso_s2_q};
					if (!cpha && state_q == ST_TRAIL) mosi <= shift_q[DATA_W-2];
				end
			end else if (!cpha && state_q == ST_TRAIL && !last_bit) begin
				mosi <= out_bit(shift_q, lsb_first);
			end
		end
	end

	// receive byte is complete after the sampling edge of bit eight
	logic rx_complete;
	logic [DATA_W-1:0] rx_word;
	assign rx_complete = sample_bit && last_bit && (state_q != ST_IDLE);
	assign rx_word = lsb_first ? {miso_s2_q, shift_q[DATA_W-1:1]} :
		{shift_q[DATA_W-2:0], miso_s2_q};

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_data <= BYTE_RESET;
			rx_full <= 1'b0;
			overrun <= 1'b0;
		end else begin
			if (rx_complete) begin
				rx_data <= rx_word;
				rx_full <= 1'b1;
				if (rx_full && !rx_read) overrun <= 1'b1;
			end else if (rx_read) begin
				rx_full <= 1'b0;
				overrun <= 1'b0;
			end
		end
	end

	// done rises when the last trailing edge finishes; a load on a later cycle or disable clears it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			done <= 1'b0;
			moved_q <= 1'b0;
		end else begin
			moved_q <= load_now;
			if (finish) begin
				done <= 1'b1;
			end else if (load_now || !enable) begin
				done <= 1'b0;
			end
		end
	end

	// event select: shift finished (done level) or holding buffer moved (one pulse)
	always_comb begin
		irq = int_enable && (irq_on_shift_finished ? done : moved_q);
	end

	assign busy = (state_q != ST_IDLE);

	a_empty_after_load: assert property (@(posedge mclk) disable iff (rst)
		(load_now && !tx_write) |=> tx_empty) else $error("empty not set after load");
	a_write_clears: assert property (@(posedge mclk) disable iff (rst)
		tx_write |=> !tx_empty) else $error("write did not clear empty");
	a_idle_level: assert property (@(posedge mclk) disable iff (rst)
		(!busy && $past(!busy) && !load_now && $past(enable)) |-> sclk == cpol)
		else $error("sclk not at idle level");
	a_no_gap: assert property (@(posedge mclk) disable iff (rst)
		(finish && !tx_empty && enable) |=> busy) else $error("gap before preloaded byte");
	a_done_irq: assert property (@(posedge mclk) disable iff (rst)
		(finish && int_enable && irq_on_shift_finished) |=> irq)
		else $error("done did not raise irq");
	a_rx_store: assert property (@(posedge mclk) disable iff (rst)
		rx_complete |=> (rx_full && rx_data == $past(rx_word))) else $error("rx byte not stored");
	a_overrun_set: assert property (@(posedge mclk) disable iff (rst)
		(rx_complete && rx_full && !rx_read) |=> overrun) else $error("overrun missed");
	a_disable_stop: assert property (@(posedge mclk) disable iff (rst)
		!enable |=> !busy) else $error("block runs while disabled");
	a_byte_edges: assert property (@(posedge mclk) disable iff (rst)
		(busy && $past(busy)) |-> bitcnt_q < 4'(DATA_W)) else $error("bit count past eight");
endmodule
`default_nettype wire

// ---- design/spi_master_pkg.sv ----
// constants shared by the serial master unit and its bit-rate divider
// assumes a single clock domain on mclk
package spi_master_pkg;
	localparam int BYTE_BITS = 8;
	localparam logic [2:0] DIV_SEL_RESET = 3'h0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [3:0] BITCNT_RESET = 4'h0;
	localparam logic [7:0] DIVCNT_RESET = 8'h00;
	localparam int SYNC_STAGES = 2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LEAD = 2'b01,
		ST_TRAIL = 2'b10
	} shift_state_type;
endpackage

// ---- design/rate_divider.sv ----
// tick generator: one pulse every 2^(sel) system_clock cycles (sel 0 = every cycle)
// assumes sel is static while enabled; restarts when run is low
`timescale 1ns/1ps
`default_nettype none
module rate_divider
	import spi_master_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic run,
	input wire logic [2:0] sel,
	output logic tick
);
	logic [7:0] cnt_q;
	logic [7:0] limit;

	assign limit = 8'(({8'h00, 1'b1} << sel) - 9'h001);
	assign tick = run && (cnt_q == limit);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_q <= DIVCNT_RESET;
		end else if (!run || tick) begin
			cnt_q <= DIVCNT_RESET;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ---- verification/spi_slave_model.sv ----
// behavioural spi slave: shifts out a fixed reply byte, captures what the master sends
// assumes ss_n comes from the bench; while deselected miso shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic [1:0] mode,
	input wire logic lsb_first,
	input wire logic [7:0] reply,
	output logic miso,
	output logic [7:0] got
);
	int n = 0;
	logic bit_q = 1'b0;
	function automatic int pos(int i);
		return lsb_first ? i : 7 - i;
	endfunction
	always @(negedge ss_n) begin
		n = 0;
		if (!mode[1]) bit_q = reply[pos(0)];
	end
	// phase 0 needs a fresh select per byte, so no restart after the eighth sample
	always @(sclk) begin
		if (!ss_n && ((sclk != mode[0]) ^ mode[1])) begin
			got[pos(n)] = mosi;
			n = (n + 1) % 8;
		end else if (!ss_n && (mode[1] || n != 0)) begin
			bit_q = reply[pos(n)];
		end
	end
	assign miso = ss_n ? ~bit_q : bit_q;
endmodule
`default_nettype wire

// ---- verification/spi_master_8bit_tb_top.sv ----
// self-checking bench for serial_master_unit with a behavioural slave on the far side
// assumes flags settle within one mclk after the edge that changes them
`timescale 1ns/1ps
`default_nettype none
module spi_master_8bit_tb_top;
	import spi_master_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, enable = 1'b0, lsb_first = 1'b0, int_enable = 1'b1;
	logic irq_on_shift_finished = 1'b1, tx_write = 1'b0, rx_read = 1'b0, ss_n = 1'b1;
	logic [1:0] mode = 2'h0;
	logic [2:0] clk_sel = 3'h2;
	logic [7:0] tx_data = 8'h00, rx_data, got, b;
	logic sclk, mosi, miso, tx_empty, rx_full, done, overrun, busy, irq;
	logic sclk_p = 1'b0, busy_p = 1'b0;
	int n_fail = 0, checked = 0, cnt = 0, half = 0, drops = 0, irqs = 0, k;
	always #12.5 mclk = ~mclk;
	serial_master_unit dut (.mclk(mclk), .rst(rst), .enable(enable), .mode(mode),
		.lsb_first(lsb_first), .clk_sel(clk_sel), .int_enable(int_enable),
		.irq_on_shift_finished(irq_on_shift_finished), .tx_data(tx_data), .tx_write(tx_write),
		.rx_read(rx_read), .miso(miso), .sclk(sclk), .mosi(mosi), .rx_data(rx_data),
		.tx_empty(tx_empty), .rx_full(rx_full), .done(done), .overrun(overrun), .busy(busy),
		.irq(irq));
	spi_slave_model slave (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .mode(mode),
		.lsb_first(lsb_first), .reply(8'hC5), .miso(miso), .got(got));
	// half period of sclk in mclk cycles, busy falls and irq cycles seen
	always @(posedge mclk) begin
		cnt <= (sclk !== sclk_p) ? 1 : cnt + 1;
		if (sclk !== sclk_p) half <= cnt;
		if (busy_p === 1'b1 && busy === 1'b0) drops <= drops + 1;
		if (irq === 1'b1) irqs <= irqs + 1;
		sclk_p <= sclk;
		busy_p <= busy;
	end
	task check(string what, logic [7:0] seen, logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task final_report;
		if (n_fail == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task step(int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask
	task send(logic [7:0] v);
		@(posedge mclk);
		tx_data <= v;
		tx_write <= 1'b1;
		@(posedge mclk);
		tx_write <= 1'b0;
		#1;
	endtask
	task read_rx;
		@(posedge mclk);
		rx_read <= 1'b1;
		@(posedge mclk);
		rx_read <= 1'b0;
		#1;
	endtask
	task wait_done;
		for (int i = 0; i < 3000; i++) begin
			step(1);
			if (done === 1'b1) return;
		end
		n_fail++;
		final_report;
	endtask
	task wait_idle;
		for (int i = 0; i < 3000; i++) begin
			step(1);
			if (busy === 1'b0) return;
		end
		n_fail++;
		final_report;
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			@(posedge mclk);
			enable <= 1'b0;
			// configuration moves only while disabled, one edge after enable falls
			@(posedge mclk);
			mode <= m[1:0];
			lsb_first <= m[0];
			clk_sel <= 3'(m + 2);
			irq_on_shift_finished <= (m != 2);
			@(posedge mclk);
			enable <= 1'b1;
			step(3);
			check("sclk idle", 8'(sclk), 8'(mode[0]));
			@(posedge mclk);
			ss_n <= 1'b0;
			k = irqs;
			b = 8'h1D + 8'(m);
			send(b);
			check("tx_empty after write", 8'(tx_empty), 8'h00);
			step(1);
			check("load flags", 8'({tx_empty, busy}), 8'h03);
			wait_done;
			check("rx_data", rx_data, 8'hC5);
			check("slave got", got, b);
			check("rx flags", 8'({rx_full, done, overrun}), 8'h06);
			check("half period", 8'(half), 8'(1 << (m + 2)));
			if (m == 2) check("irq pulses", 8'(irqs - k), 8'h01);
			else check("irq", 8'(irq), 8'h01);
			read_rx;
			check("rx_full read", 8'(rx_full), 8'h00);
			@(posedge mclk);
			ss_n <= 1'b1;
			step(2);
		end
		@(posedge mclk);
		ss_n <= 1'b0;
		k = drops;
		send(8'h3A);
		step(1);
		check("tx_empty before preload", 8'(tx_empty), 8'h01);
		send(8'h6B);
		wait_done;
		step(2);
		// done stays set across a back-to-back load, so the second byte ends when busy falls
		wait_idle;
		step(2);
		check("second byte", got, 8'h6B);
		check("no gap", 8'(drops - k), 8'h01);
		check("overrun", 8'({rx_full, overrun}), 8'h03);
		@(posedge mclk);
		int_enable <= 1'b0;
		step(1);
		check("irq masked", 8'(irq), 8'h00);
		read_rx;
		check("overrun read", 8'({rx_full, overrun}), 8'h00);
		@(posedge mclk);
		ss_n <= 1'b1;
		enable <= 1'b0;
		send(8'h55);
		step(6);
		check("stopped", 8'({busy, sclk}), 8'h01);
		final_report;
	end
endmodule
`default_nettype wire
